// *** hdl/sfpe_regs.svh ***
`ifndef SFPE_REGS_SVH
`define SFPE_REGS_SVH

// clock and timing figures
`define SFPE_CLK_MHZ      100
`define SFPE_CLK_NS       10
`define SFPE_T_VCSL_US    70
`define SFPE_T_PUW_MS     20
`define SFPE_T_CS_NS      50

// least times round up, longest times round down
`define SFPE_SEL_DLY_CYC  (`SFPE_T_VCSL_US * `SFPE_CLK_MHZ)
`define SFPE_WR_DLY_CYC   (`SFPE_T_PUW_MS * 1000 * `SFPE_CLK_MHZ)
`define SFPE_CS_HIGH_CYC  ((`SFPE_T_CS_NS + `SFPE_CLK_NS - 1) / `SFPE_CLK_NS)

// host serial clock: core cycles per half period
`define SFPE_SCK_HALF     4'h4
`define SFPE_DIV_ZERO     4'h0
`define SFPE_DIV_ONE      4'h1

// opcodes with a known address layout
`define SFPE_OP_PAGE      8'he8
`define SFPE_OP_BUF       8'hd6

// frame lengths in bits
`define SFPE_HDR_BITS     6'h20
`define SFPE_RD_BITS      6'h28
`define SFPE_BIT_ZERO     6'h00
`define SFPE_BIT_ONE      6'h01

// address field positions
`define SFPE_OP_MSB       31
`define SFPE_OP_LSB       24
`define SFPE_ADDR_MSB     23
`define SFPE_PAGE_MSB     22
`define SFPE_PAGE_LSB     10
`define SFPE_BYTE_MSB     9
`define SFPE_BYTE_LSB     0

// reset values
`define SFPE_MODE_RST     1'b1
`define SFPE_PAGE_NONE    13'h0000
`define SFPE_BYTE_NONE    10'h000
`define SFPE_CNT_ZERO     32'h0000_0000
`define SFPE_CNT_ONE      32'h0000_0001
`define SFPE_DATA_NONE    8'h00
`define SFPE_ADDR_NONE    24'h00_0000
`define SFPE_SH_NONE      40'h00_0000_0000

// shift register bit positions
`define SFPE_HDR_KEEP     30
`define SFPE_DATA_MSB     7
`define SFPE_DATA_KEEP    6
`define SFPE_SH_MSB       39
`define SFPE_SH_KEEP      38

`endif

// *** hdl/sfpe_pkg.sv ***
`include "sfpe_regs.svh"

package sfpe_pkg;

    typedef enum logic [1:0] {
        DEV_POR,
        DEV_STANDBY,
        DEV_SHIFT,
        DEV_HOLD
    } sfpe_dev_e;

    typedef enum logic [2:0] {
        HST_POWERUP,
        HST_IDLE,
        HST_SHIFT,
        HST_GAP
    } sfpe_host_e;

    typedef enum logic [1:0] {
        FMT_OTHER,
        FMT_PAGE,
        FMT_BUFFER
    } sfpe_fmt_e;

    function automatic sfpe_fmt_e fmt_of(input logic [7:0] op);
        if (op == `SFPE_OP_PAGE) begin
            return FMT_PAGE;
        end else if (op == `SFPE_OP_BUF) begin
            return FMT_BUFFER;
        end
        return FMT_OTHER;
    endfunction

    function automatic logic [12:0] page_of(input logic [7:0]  op,
                                            input logic [23:0] a);
        if (fmt_of(op) == FMT_PAGE) begin
            return a[`SFPE_PAGE_MSB:`SFPE_PAGE_LSB];
        end
        return `SFPE_PAGE_NONE;
    endfunction

    function automatic logic [9:0] byte_of(input logic [7:0]  op,
                                           input logic [23:0] a);
        if (fmt_of(op) != FMT_OTHER) begin
            return a[`SFPE_BYTE_MSB:`SFPE_BYTE_LSB];
        end
        return `SFPE_BYTE_NONE;
    endfunction

endpackage

// *** hdl/sfpe_spi_if.sv ***
interface sfpe_spi_if;
    logic cs_n;
    logic sck;
    logic si;
    logic so_out;
    logic so_oe_n;
    wire  so;

    // released line rests at its pull-up level
    assign so = so_oe_n ? 1'b1 : so_out;

    modport dev  (input cs_n, input sck, input si,
                  output so_out, output so_oe_n);
    modport host (output cs_n, output sck, output si, input so);
endinterface

// *** hdl/sfpe_device.sv ***
`include "sfpe_regs.svh"

// What this block does
// - mode 3 after power-up or reset
// - output undriven until data is needed
// - instruction starts only on select fall
// - idle clock at select fall picks mode
// - below threshold: held in reset, ignore all
// - host waits 70 us before selecting
// - host waits 20 ms before writes
// - after power-up sit in standby
// - E8h: don't care, 13 page, 10 byte
// - D6h: 14 don't care, 10 buffer byte
module sfpe_device #(
    parameter int WR_DLY_CYC = `SFPE_WR_DLY_CYC
) (
    input  wire logic          CORE_CLK,
    input  wire logic          ARST_N,
    input  wire logic          POR_ACTIVE,
    input  wire logic          TX_ENABLE,
    input  wire logic [7:0]    TX_DATA,
    output logic               TX_TAKEN,
    output logic               CMD_VALID,
    output logic [7:0]         CMD_OPCODE,
    output logic [23:0]        CMD_ADDR,
    output logic [12:0]        CMD_PAGE,
    output logic [9:0]         CMD_BYTE,
    output sfpe_pkg::sfpe_fmt_e CMD_FMT,
    output logic               MODE3,
    output logic               STANDBY,
    output logic               WRITE_OK,
    sfpe_spi_if.dev            SPI
);

    sfpe_pkg::sfpe_dev_e state;
    logic                cs_q;
    logic                sck_q;
    logic                cs_fall;
    logic                sck_rise;
    logic                sck_fall;
    logic                last_bit;
    logic [5:0]          bit_cnt;
    logic [31:0]         hdr;
    logic [31:0]         next_hdr;
    logic [7:0]          tx;
    logic                tx_live;
    logic [31:0]         wr_cnt;

    // edges of the sampled pins
    assign cs_fall  = cs_q & ~SPI.cs_n;
    assign sck_rise = ~SPI.cs_n & ~sck_q & SPI.sck;
    assign sck_fall = ~SPI.cs_n & sck_q & ~SPI.sck;
    assign last_bit = (bit_cnt == (`SFPE_HDR_BITS - `SFPE_BIT_ONE));
    assign next_hdr = {hdr[`SFPE_HDR_KEEP:0], SPI.si};

    // cs_q clears in reset so a low select is not seen as a fall
    always_ff @(posedge CORE_CLK or negedge ARST_N) begin
        if (!ARST_N) begin
            cs_q  <= 1'b0;
            sck_q <= 1'b0;
        end else if (POR_ACTIVE) begin
            cs_q  <= 1'b0;
            sck_q <= 1'b0;
        end else begin
            cs_q  <= SPI.cs_n;
            sck_q <= SPI.sck;
        end
    end

    always_ff @(posedge CORE_CLK or negedge ARST_N) begin
        if (!ARST_N) begin
            state <= sfpe_pkg::DEV_POR;
        end else if (POR_ACTIVE) begin
            state <= sfpe_pkg::DEV_POR;
        end else begin
            case (state)
                sfpe_pkg::DEV_POR: begin
                    state <= sfpe_pkg::DEV_STANDBY;
                end
                sfpe_pkg::DEV_STANDBY: begin
                    if (cs_fall) begin
                        state <= sfpe_pkg::DEV_SHIFT;
                    end
                end
                sfpe_pkg::DEV_SHIFT: begin
                    if (SPI.cs_n) begin
                        state <= sfpe_pkg::DEV_STANDBY;
                    end else if (sck_rise && last_bit) begin
                        state <= sfpe_pkg::DEV_HOLD;
                    end
                end
                sfpe_pkg::DEV_HOLD: begin
                    if (SPI.cs_n) begin
                        state <= sfpe_pkg::DEV_STANDBY;
                    end
                end
                default: begin
                    state <= sfpe_pkg::DEV_STANDBY;
                end
            endcase
        end
    end

    // clock mode, latched at every select fall
    always_ff @(posedge CORE_CLK or negedge ARST_N) begin
        if (!ARST_N) begin
            MODE3 <= `SFPE_MODE_RST;
        end else if (POR_ACTIVE) begin
            MODE3 <= `SFPE_MODE_RST;
        end else if (cs_fall) begin
            MODE3 <= SPI.sck;
        end
    end

    // header shift register, msb first
    always_ff @(posedge CORE_CLK or negedge ARST_N) begin
        if (!ARST_N) begin
            hdr     <= `SFPE_CNT_ZERO;
            bit_cnt <= `SFPE_BIT_ZERO;
        end else if (POR_ACTIVE || cs_fall) begin
            hdr     <= `SFPE_CNT_ZERO;
            bit_cnt <= `SFPE_BIT_ZERO;
        end else if (state == sfpe_pkg::DEV_SHIFT && sck_rise) begin
            hdr     <= next_hdr;
            bit_cnt <= bit_cnt + `SFPE_BIT_ONE;
        end
    end

    // decoded command, one pulse per complete header
    always_ff @(posedge CORE_CLK or negedge ARST_N) begin
        if (!ARST_N) begin
            CMD_VALID  <= 1'b0;
            CMD_OPCODE <= `SFPE_DATA_NONE;
            CMD_ADDR   <= `SFPE_ADDR_NONE;
            CMD_PAGE   <= `SFPE_PAGE_NONE;
            CMD_BYTE   <= `SFPE_BYTE_NONE;
            CMD_FMT    <= sfpe_pkg::FMT_OTHER;
        end else if (POR_ACTIVE) begin
            CMD_VALID  <= 1'b0;
        end else if (state == sfpe_pkg::DEV_SHIFT && sck_rise
                     && last_bit) begin
            CMD_VALID  <= 1'b1;
            CMD_OPCODE <= next_hdr[`SFPE_OP_MSB:`SFPE_OP_LSB];
            CMD_ADDR   <= next_hdr[`SFPE_ADDR_MSB:0];
            CMD_FMT    <= sfpe_pkg::fmt_of(
                              next_hdr[`SFPE_OP_MSB:`SFPE_OP_LSB]);
            CMD_PAGE   <= sfpe_pkg::page_of(
                              next_hdr[`SFPE_OP_MSB:`SFPE_OP_LSB],
                              next_hdr[`SFPE_ADDR_MSB:0]);
            CMD_BYTE   <= sfpe_pkg::byte_of(
                              next_hdr[`SFPE_OP_MSB:`SFPE_OP_LSB],
                              next_hdr[`SFPE_ADDR_MSB:0]);
        end else begin
            CMD_VALID  <= 1'b0;
        end
    end

    // return data: loaded once the header is in, if asked for
    always_ff @(posedge CORE_CLK or negedge ARST_N) begin
        if (!ARST_N) begin
            tx       <= `SFPE_DATA_NONE;
            tx_live  <= 1'b0;
            TX_TAKEN <= 1'b0;
        end else if (POR_ACTIVE || SPI.cs_n) begin
            tx_live  <= 1'b0;
            TX_TAKEN <= 1'b0;
        end else if (state == sfpe_pkg::DEV_SHIFT && sck_rise
                     && last_bit && TX_ENABLE) begin
            tx       <= TX_DATA;
            tx_live  <= 1'b1;
            TX_TAKEN <= 1'b1;
        end else if (tx_live && sck_fall) begin
            tx       <= {tx[`SFPE_DATA_KEEP:0], tx[`SFPE_DATA_MSB]};
            TX_TAKEN <= 1'b0;
        end else begin
            TX_TAKEN <= 1'b0;
        end
    end

    // output changes on falling clock; released with the select
    always_ff @(posedge CORE_CLK or negedge ARST_N) begin
        if (!ARST_N) begin
            SPI.so_out  <= 1'b0;
            SPI.so_oe_n <= 1'b1;
        end else if (POR_ACTIVE || SPI.cs_n || !tx_live) begin
            SPI.so_out  <= 1'b0;
            SPI.so_oe_n <= 1'b1;
        end else if (sck_fall) begin
            SPI.so_out  <= tx[`SFPE_DATA_MSB];
            SPI.so_oe_n <= 1'b0;
        end
    end

    // write lockout timer from the end of power-on reset
    always_ff @(posedge CORE_CLK or negedge ARST_N) begin
        if (!ARST_N) begin
            wr_cnt   <= `SFPE_CNT_ZERO;
            WRITE_OK <= 1'b0;
        end else if (POR_ACTIVE) begin
            wr_cnt   <= `SFPE_CNT_ZERO;
            WRITE_OK <= 1'b0;
        end else if (wr_cnt != 32'(WR_DLY_CYC)) begin
            wr_cnt   <= wr_cnt + `SFPE_CNT_ONE;
        end else begin
            WRITE_OK <= 1'b1;
        end
    end

    assign STANDBY = (state == sfpe_pkg::DEV_STANDBY);

endmodule // sfpe_device

// *** hdl/sfpe_host.sv ***
`include "sfpe_regs.svh"

module sfpe_host #(
    parameter int SEL_DLY_CYC = `SFPE_SEL_DLY_CYC,
    parameter int WR_DLY_CYC  = `SFPE_WR_DLY_CYC
) (
    input  wire logic        CORE_CLK,
    input  wire logic        ARST_N,
    input  wire logic        SCK_IDLE_HIGH,
    input  wire logic        REQ,
    input  wire logic [7:0]  REQ_OPCODE,
    input  wire logic [23:0] REQ_ADDR,
    input  wire logic        REQ_WRITE,
    input  wire logic        REQ_READ,
    output logic             READY,
    output logic             WRITE_OK,
    output logic             DONE,
    output logic [7:0]       RD_DATA,
    sfpe_spi_if.host         SPI
);

    sfpe_pkg::sfpe_host_e state;
    logic [31:0]          dly;
    logic [31:0]          wr_cnt;
    logic [3:0]           div;
    logic                 tick;
    logic [39:0]          sh;
    logic [5:0]           cnt;
    logic [5:0]           total;
    logic                 idle_hi;

    assign tick  = (div == (`SFPE_SCK_HALF - `SFPE_DIV_ONE));
    assign READY = (state == sfpe_pkg::HST_IDLE)
                   && (!REQ_WRITE || WRITE_OK);

    always_ff @(posedge CORE_CLK or negedge ARST_N) begin
        if (!ARST_N) begin
            wr_cnt   <= `SFPE_CNT_ZERO;
            WRITE_OK <= 1'b0;
        end else if (wr_cnt != 32'(WR_DLY_CYC)) begin
            wr_cnt   <= wr_cnt + `SFPE_CNT_ONE;
        end else begin
            WRITE_OK <= 1'b1;
        end
    end

    always_ff @(posedge CORE_CLK or negedge ARST_N) begin
        if (!ARST_N) begin
            div <= `SFPE_DIV_ZERO;
        end else if (state != sfpe_pkg::HST_SHIFT || tick) begin
            div <= `SFPE_DIV_ZERO;
        end else begin
            div <= div + `SFPE_DIV_ONE;
        end
    end

    always_ff @(posedge CORE_CLK or negedge ARST_N) begin
        if (!ARST_N) begin
            state   <= sfpe_pkg::HST_POWERUP;
            dly     <= `SFPE_CNT_ZERO;
            SPI.cs_n <= 1'b1;
            SPI.sck <= `SFPE_MODE_RST;
            SPI.si  <= 1'b0;
            sh      <= `SFPE_SH_NONE;
            cnt     <= `SFPE_BIT_ZERO;
            total   <= `SFPE_HDR_BITS;
            idle_hi <= `SFPE_MODE_RST;
            DONE    <= 1'b0;
            RD_DATA <= `SFPE_DATA_NONE;
        end else begin
            DONE <= 1'b0;
            case (state)
                sfpe_pkg::HST_POWERUP: begin
                    if (dly == 32'(SEL_DLY_CYC)) begin
                        state <= sfpe_pkg::HST_IDLE;
                    end else begin
                        dly <= dly + `SFPE_CNT_ONE;
                    end
                end
                sfpe_pkg::HST_IDLE: begin
                    SPI.sck <= SCK_IDLE_HIGH;
                    idle_hi <= SCK_IDLE_HIGH;
                    if (REQ && READY) begin
                        SPI.cs_n <= 1'b0;
                        sh       <= {REQ_OPCODE, REQ_ADDR,
                                     `SFPE_DATA_NONE};
                        SPI.si   <= REQ_OPCODE[`SFPE_DATA_MSB];
                        cnt      <= `SFPE_BIT_ZERO;
                        total    <= REQ_READ ? `SFPE_RD_BITS
                                             : `SFPE_HDR_BITS;
                        state    <= sfpe_pkg::HST_SHIFT;
                    end
                end
                sfpe_pkg::HST_SHIFT: begin
                    if (tick) begin
                        if (!SPI.sck && cnt == total) begin
                            SPI.cs_n <= 1'b1;
                            state    <= sfpe_pkg::HST_GAP;
                            RD_DATA  <= sh[`SFPE_DATA_MSB:0];
                            DONE     <= 1'b1;
                        end else if (!SPI.sck) begin
                            SPI.sck <= 1'b1;
                            sh      <= {sh[`SFPE_SH_KEEP:0], SPI.so};
                            cnt     <= cnt + `SFPE_BIT_ONE;
                        end else if (cnt == total && idle_hi) begin
                            SPI.cs_n <= 1'b1;
                            state    <= sfpe_pkg::HST_GAP;
                            RD_DATA  <= sh[`SFPE_DATA_MSB:0];
                            DONE     <= 1'b1;
                        end else begin
                            SPI.sck <= 1'b0;
                            SPI.si  <= sh[`SFPE_SH_MSB];
                        end
                    end
                    dly <= `SFPE_CNT_ZERO;
                end
                sfpe_pkg::HST_GAP: begin
                    if (dly == 32'(`SFPE_CS_HIGH_CYC)) begin
                        state <= sfpe_pkg::HST_IDLE;
                    end else begin
                        dly <= dly + `SFPE_CNT_ONE;
                    end
                end
                default: begin
                    state <= sfpe_pkg::HST_IDLE;
                end
            endcase
        end
    end

endmodule // sfpe_host

// *** tb/sfpe_props.sv ***
module sfpe_props #(
    parameter int SEL_DLY_CYC = 20
) (
    input wire logic CORE_CLK,
    input wire logic ARST_N,
    input wire logic cs_n,
    input wire logic sck,
    input wire logic si,
    input wire logic so_oe_n
);
    timeunit 1ns;
    timeprecision 1ns;

    logic [5:0]  rises;
    logic [31:0] since;

    default clocking cb @(posedge CORE_CLK);
    endclocking
    default disable iff (!ARST_N);

    // serial clock rises within the current select
    always_ff @(posedge CORE_CLK or negedge ARST_N) begin
        if (!ARST_N) begin
            rises <= 6'h00;
        end else if (cs_n) begin
            rises <= 6'h00;
        end else if ($rose(sck)) begin
            rises <= rises + 6'h01;
        end
    end

    // cycles since reset release, saturating
    always_ff @(posedge CORE_CLK or negedge ARST_N) begin
        if (!ARST_N) begin
            since <= 32'h0000_0000;
        end else if (since <= SEL_DLY_CYC) begin
            since <= since + 32'h0000_0001;
        end
    end

    chk_reset_quiet: assert property (
        $rose(ARST_N) |-> (so_oe_n && cs_n)[*2])
        else $error("output or select active after reset");
    chk_so_release: assert property (
        $rose(cs_n) |-> ##[1:2] so_oe_n)
        else $error("serial output held after deselect");
    chk_so_after_hdr: assert property (
        $fell(so_oe_n) |-> !cs_n && rises == 6'h20)
        else $error("serial output driven before header end");
    chk_cs_gap: assert property (
        $rose(cs_n) |-> cs_n[*6])
        else $error("select high time too short");
    chk_first_select: assert property (
        $fell(cs_n) |-> since > SEL_DLY_CYC)
        else $error("select too soon after reset");
    chk_si_steady: assert property (
        !cs_n && !$past(cs_n) && sck && $past(sck) |-> $stable(si))
        else $error("serial input moved while clock high");
    chk_sck_high: assert property (
        $rose(sck) && !cs_n |-> sck[*4])
        else $error("serial clock high phase wrong");
    chk_frame_bits: assert property (
        $rose(cs_n) |-> rises == 6'h20 || rises == 6'h28)
        else $error("frame bit count wrong");

    cov_mode3: cover property ($fell(cs_n) && sck);
    cov_mode0: cover property ($fell(cs_n) && !sck);
    cov_so_on: cover property ($fell(so_oe_n));
endmodule // sfpe_props

// *** tb/tb.sv ***
module tb;
    timeunit 1ns;
    timeprecision 1ns;

    localparam int SEL = 20;
    localparam int WR  = 50;

    typedef struct {
        logic [31:0]         hdr;
        logic [12:0]         page;
        logic [9:0]          byt;
        sfpe_pkg::sfpe_fmt_e fmt;
        logic                mode3;
        logic                tx;
        logic [7:0]          data;
    } sfpe_note_s;

    logic                core_clk = 1'b0;
    logic                arst_n = 1'b0;
    logic                por_active = 1'b0;
    logic                tx_enable = 1'b0;
    logic [7:0]          tx_data = 8'h00;
    logic                sck_idle_high = 1'b1;
    logic                req = 1'b0;
    logic [7:0]          req_opcode = 8'h00;
    logic [23:0]         req_addr = 24'h000000;
    logic                req_write = 1'b0;
    logic                req_read = 1'b0;
    logic                cmd_valid, mode3, standby, dev_wr_ok, tx_taken;
    logic                ready, host_wr_ok, done;
    logic [7:0]          cmd_opcode, rd_data;
    logic [23:0]         cmd_addr;
    logic [12:0]         cmd_page;
    logic [9:0]          cmd_byte;
    sfpe_pkg::sfpe_fmt_e cmd_fmt;
    int                  miscompares = 0;
    int                  compares = 0;
    int                  cyc = 0;
    int                  nbits = 0;
    logic [39:0]         sh = 40'h0;
    sfpe_note_s          hq[$];
    sfpe_note_s          dq[$];

    sfpe_spi_if spi ();

    sfpe_device #(.WR_DLY_CYC(WR)) u_sfpe_device (
        .CORE_CLK(core_clk), .ARST_N(arst_n), .POR_ACTIVE(por_active),
        .TX_ENABLE(tx_enable), .TX_DATA(tx_data), .TX_TAKEN(tx_taken),
        .CMD_VALID(cmd_valid), .CMD_OPCODE(cmd_opcode),
        .CMD_ADDR(cmd_addr), .CMD_PAGE(cmd_page), .CMD_BYTE(cmd_byte),
        .CMD_FMT(cmd_fmt), .MODE3(mode3), .STANDBY(standby),
        .WRITE_OK(dev_wr_ok), .SPI(spi));

    sfpe_host #(.SEL_DLY_CYC(SEL), .WR_DLY_CYC(WR)) u_sfpe_host (
        .CORE_CLK(core_clk), .ARST_N(arst_n),
        .SCK_IDLE_HIGH(sck_idle_high), .REQ(req),
        .REQ_OPCODE(req_opcode), .REQ_ADDR(req_addr),
        .REQ_WRITE(req_write), .REQ_READ(req_read), .READY(ready),
        .WRITE_OK(host_wr_ok), .DONE(done), .RD_DATA(rd_data), .SPI(spi));

    sfpe_props #(.SEL_DLY_CYC(SEL)) u_sfpe_props (
        .CORE_CLK(core_clk), .ARST_N(arst_n), .cs_n(spi.cs_n),
        .sck(spi.sck), .si(spi.si), .so_oe_n(spi.so_oe_n));

    always #5 core_clk = ~core_clk;

    task automatic wrap_up();
        if (miscompares == 0 && compares > 0) begin
            $display("No errors found");
        end else begin
            $display("Errors were found");
        end
        $finish;
    endtask

    always @(posedge core_clk) begin
        cyc++;
        if (cyc > 20000) begin
            miscompares++;
            wrap_up();
        end
    end

    task automatic chk(input string what, input logic [63:0] seen,
                       input logic [63:0] exp);
        compares++;
        if (seen !== exp) begin
            miscompares++;
            $display("mismatch %s expected %h seen %h", what, exp, seen);
        end
    endtask

    // bits on the wire as the device would sample them
    always @(negedge spi.cs_n) nbits = 0;
    always @(posedge spi.sck) begin
        if (!spi.cs_n) begin
            sh = {sh[38:0], spi.si};
            nbits++;
        end
    end

    always @(negedge core_clk) begin
        sfpe_note_s n;
        if (cmd_valid === 1'b1) begin
            if (hq.size() == 0) begin
                chk("stray header", 1'b1, 1'b0);
            end else begin
                n = hq.pop_front();
                chk("header", {cmd_opcode, cmd_addr}, n.hdr);
                chk("page", cmd_page, n.page);
                chk("byte", cmd_byte, n.byt);
                chk("format", cmd_fmt, n.fmt);
                chk("mode", mode3, n.mode3);
                chk("tx taken", tx_taken, n.tx);
            end
        end
        if (done === 1'b1 && dq.size() > 0) begin
            n = dq.pop_front();
            chk("wire bits", 32'(sh >> (nbits - 32)), n.hdr);
            if (n.tx) begin
                chk("read byte", rd_data, n.data);
            end else begin
                chk("output idle", spi.so_oe_n, 1'b1);
            end
        end
    end

    task automatic power_up();
        int n;
        req_write = 1'b0;
        arst_n = 1'b1;
        for (n = 1; n <= WR + 3; n++) begin
            @(negedge core_clk);
            chk("ready", ready, n > SEL && (n <= SEL + 3 || n > WR));
            chk("write ok", {host_wr_ok, dev_wr_ok}, {2{n > WR}});
            chk("so after reset", spi.so_oe_n, 1'b1);
            if (n == 2) chk("standby", standby, 1'b1);
            req_write = n >= SEL + 3;
        end
    endtask

    task automatic send(input logic [7:0] op, input logic [23:0] a,
                        input logic m3, input logic rd, input logic tx,
                        input logic hdr_ok);
        sfpe_note_s n;
        int i;
        n.hdr = {op, a};
        n.mode3 = m3;
        n.page = (op == 8'he8) ? a[22:10] : 13'h0000;
        n.byt = (op == 8'he8 || op == 8'hd6) ? a[9:0] : 10'h000;
        n.fmt = sfpe_pkg::FMT_OTHER;
        if (op == 8'he8) n.fmt = sfpe_pkg::FMT_PAGE;
        if (op == 8'hd6) n.fmt = sfpe_pkg::FMT_BUFFER;
        n.tx = rd & tx;
        @(negedge core_clk);
        sck_idle_high = m3;
        tx_enable = n.tx;
        tx_data = 8'($urandom);
        n.data = tx_data;
        repeat (2) @(negedge core_clk);
        req = 1'b1;
        req_opcode = op;
        req_addr = a;
        req_read = rd;
        if (hdr_ok) hq.push_back(n);
        dq.push_back(n);
        for (i = 0; i < 100 && ready !== 1'b1; i++) @(negedge core_clk);
        @(negedge core_clk);
        req = 1'b0;
        for (i = 0; i < 600 && done !== 1'b1; i++) @(negedge core_clk);
        chk("done", done, 1'b1);
        repeat (8) @(negedge core_clk);
    endtask

    initial begin
        int i;
        logic [31:0] r;
        void'($urandom(32'h968d0b6b));
        repeat (3) @(negedge core_clk);
        chk("reset mode", mode3, 1'b1);
        chk("reset standby", standby, 1'b0);
        power_up();
        send(8'he8, 24'hffffff, 1'b0, 1'b0, 1'b0, 1'b1);
        send(8'hd6, 24'hffffff, 1'b1, 1'b1, 1'b1, 1'b1);
        for (i = 0; i < 12; i++) begin
            r = $urandom;
            req_opcode = (i % 3 == 0) ? 8'he8 : (i % 3 == 1) ? 8'hd6 : r[31:24];
            send(req_opcode, r[23:0], r[i % 24], r[(i + 5) % 24],
                 r[(i + 9) % 24], 1'b1);
        end
        send(8'h0b, 24'h5a5a5a, 1'b0, 1'b1, 1'b1, 1'b1);
        @(negedge core_clk);
        arst_n = 1'b0;
        repeat (3) @(negedge core_clk);
        chk("mode after reset", mode3, 1'b1);
        power_up();
        chk("mode kept idle", mode3, 1'b1);
        por_active = 1'b1;
        send(8'he8, 24'h123456, 1'b0, 1'b0, 1'b0, 1'b0);
        chk("por standby", standby, 1'b0);
        chk("por write ok", dev_wr_ok, 1'b0);
        por_active = 1'b0;
        repeat (3) @(negedge core_clk);
        chk("standby after por", standby, 1'b1);
        chk("write lockout", dev_wr_ok, 1'b0);
        send(8'hd6, 24'h0003ff, 1'b0, 1'b1, 1'b1, 1'b1);
        chk("pending headers", hq.size(), 0);
        wrap_up();
    end
endmodule // tb
